// [common/otfs_defines.svh]
// Purpose: Constants for the output terminal function selector
// Assumes: APB data is 32 bits wide; registers sit on aligned words
// Notes:   Codes index a source vector; gaps in it stay zero
`ifndef OTFS_DEFINES_SVH
`define OTFS_DEFINES_SVH

`define OTFS_NUM_TERM   6
`define OTFS_CODE_W     8
`define OTFS_ADDR_W     8
`define OTFS_SRC_W      128

// Register byte offsets
`define OTFS_OFF_SEL0   8'h00
`define OTFS_OFF_STATUS 8'h18

// Select values after reset, terminal 5 in the top byte
`define OTFS_SEL_RST    {8'h41, 8'h42, 8'h43, 8'h49, 8'h45, 8'h46}

// Assignment codes
`define OTFS_C_UNUSED    0
`define OTFS_C_FORWARD   1
`define OTFS_C_REVERSE   2
`define OTFS_C_HOME      3
`define OTFS_C_START     4
`define OTFS_C_SEQ_BEGIN 5
`define OTFS_C_JOGP      6
`define OTFS_C_JOGM      7
`define OTFS_C_DIRECT0   8
`define OTFS_C_FREE      16
`define OTFS_C_CON       17
`define OTFS_C_STOP      18
`define OTFS_C_GEN0      32
`define OTFS_C_DN0       48
`define OTFS_C_PLS       60
`define OTFS_C_MLS       61
`define OTFS_C_ORG       62
`define OTFS_C_SLOT      63
`define OTFS_C_ALARM     65
`define OTFS_C_WARNING   66
`define OTFS_C_READY     67
`define OTFS_C_MOVE      68
`define OTFS_C_END       69
`define OTFS_C_HOMEP     70
`define OTFS_C_TORQUE    71
`define OTFS_C_SHAFT     72
`define OTFS_C_ZONE1     73
`define OTFS_C_BUSY      80
`define OTFS_C_POWER     82

`define OTFS_NUM_MS     6
`define OTFS_NUM_DN     6
`define OTFS_NUM_GEN    16
`define OTFS_NUM_ZONE   3

`endif

// [common/otfs_pkg.sv]
// Purpose: Types for the output terminal function selector
// Assumes: otfs_defines.svh supplies all widths except the 32-bit read data
// Notes:   Whole module state lives in one packed struct
`include "otfs_defines.svh"

package otfs_pkg;

	typedef logic [`OTFS_CODE_W-1:0] otfs_code_t;
	typedef logic [`OTFS_ADDR_W-1:0] otfs_addr_t;

	typedef struct packed {
		logic [`OTFS_NUM_TERM-1:0][`OTFS_CODE_W-1:0] sel;
		logic [`OTFS_NUM_TERM-1:0]                   term;
		logic [31:0]                                 rdata;
	} otfs_state_s;

endpackage

// [src/otfs_top.sv]
// Purpose: Routes a chosen source onto each of six output terminals
// Assumes: All source inputs are synchronous to pclk, active high
// Notes:   Terminals lag their source by one clock; APB has no wait states
// Function
// - Six terminals, each with its own writable assignment code.
// - Reset codes: 70, 69, 73, 67, 66, 65 for terminals zero to five.
// - Code zero keeps the terminal inactive.
// - Codes 1-7 and 16-18 echo the command inputs.
// - Codes 8-13 echo the six direct positioning start inputs.
// - Codes 32-47 output general bits 0-15.
// - Codes 48-53 echo data number select bits 0-5.
// - Codes 60-63 echo plus limit, minus limit, origin and slot sensors.
// - Code 65 is active while no alarm exists.
// - Code 66 is active while a warning is present.
// - Code 67 is active while the driver is ready.
// - Code 68 is active while the motor moves.
// - Code 69 is active once positioning has completed.
// - Code 70 is active while at home position.
// - Code 71 is active while load exceeds torque range.
// - Code 72 gives the shaft pulse, one per 7.2 degrees.
// - Codes 73-75 are active inside zone one, two or three.
// - Code 80 is active while internal processing runs.
// - Code 82 reflects the main power state.
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "otfs_defines.svh"

module otfs_top (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire otfs_pkg::otfs_addr_t    paddr,
	input  wire logic [31:0]             pwdata,
	input  wire logic [3:0]              pstrb,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    forward_run,
	input  wire logic                    reverse_run,
	input  wire logic                    home_cmd,
	input  wire logic                    start_cmd,
	input  wire logic                    sequential_begin,
	input  wire logic                    jog_plus,
	input  wire logic                    jog_minus,
	input  wire logic                    free_cmd,
	input  wire logic                    excite_on,
	input  wire logic                    stop_cmd,
	input  wire logic [5:0]              direct_position_sel,
	input  wire logic [5:0]              data_number_bit,
	input  wire logic [15:0]             general_bit,
	input  wire logic                    plus_limit_sensor,
	input  wire logic                    minus_limit_sensor,
	input  wire logic                    origin_sensor,
	input  wire logic                    slot_sensor,
	input  wire logic                    alarm_out,
	input  wire logic                    warning_out,
	input  wire logic                    ready_flag,
	input  wire logic                    moving_flag,
	input  wire logic                    position_end_flag,
	input  wire logic                    home_position_flag,
	input  wire logic                    torque_exceeded_flag,
	input  wire logic                    shaft_step_pulse,
	input  wire logic [2:0]              zone_flag,
	input  wire logic                    internal_processing_flag,
	input  wire logic                    main_power_state,
	output logic                         output_terminal_0,
	output logic                         output_terminal_1,
	output logic                         output_terminal_2,
	output logic                         output_terminal_3,
	output logic                         output_terminal_4,
	output logic                         output_terminal_5
);
	import otfs_pkg::*;

	localparam int NREG = `OTFS_NUM_TERM + 1;

	otfs_state_s              st_q;
	otfs_state_s              st_d;
	logic [`OTFS_SRC_W-1:0]   src;
	logic                     setup_rd;
	logic                     wr_acc;
	logic [$clog2(NREG+1)-1:0] idx;

	// Register index from address; NREG marks an unmapped word
	function automatic logic [$clog2(NREG+1)-1:0] otfs_reg_idx(input otfs_addr_t a);
		logic [$clog2(NREG+1)-1:0] r;
		r = ($clog2(NREG+1))'(NREG);
		if (a[1:0] == 2'h0 && a <= `OTFS_OFF_STATUS)
			r = ($clog2(NREG+1))'(a[`OTFS_ADDR_W-1:2]);
		return r;
	endfunction

	// Undefined codes below 128 land on zero bits of the vector; codes of 128 and up are masked off
	function automatic logic otfs_pick(input otfs_code_t c, input logic [`OTFS_SRC_W-1:0] v);
		return v[c[$clog2(`OTFS_SRC_W)-1:0]] & (c < `OTFS_SRC_W);
	endfunction

	always_comb begin
		src = '0;
		src[`OTFS_C_FORWARD]   = forward_run;
		src[`OTFS_C_REVERSE]   = reverse_run;
		src[`OTFS_C_HOME]      = home_cmd;
		src[`OTFS_C_START]     = start_cmd;
		src[`OTFS_C_SEQ_BEGIN] = sequential_begin;
		src[`OTFS_C_JOGP]   = jog_plus;
		src[`OTFS_C_JOGM]   = jog_minus;
		src[`OTFS_C_FREE]   = free_cmd;
		src[`OTFS_C_CON]    = excite_on;
		src[`OTFS_C_STOP]   = stop_cmd;
		for (int k = 0; k < `OTFS_NUM_MS; k++) begin
			src[`OTFS_C_DIRECT0 + k] = direct_position_sel[k];
		end
		for (int k = 0; k < `OTFS_NUM_GEN; k++) begin
			src[`OTFS_C_GEN0 + k] = general_bit[k];
		end
		for (int k = 0; k < `OTFS_NUM_DN; k++) begin
			src[`OTFS_C_DN0 + k] = data_number_bit[k];
		end
		src[`OTFS_C_PLS]    = plus_limit_sensor;
		src[`OTFS_C_MLS]    = minus_limit_sensor;
		src[`OTFS_C_ORG]    = origin_sensor;
		src[`OTFS_C_SLOT]   = slot_sensor;
		// Normally closed so a broken wire reads as an alarm
		src[`OTFS_C_ALARM]   = ~alarm_out;
		src[`OTFS_C_WARNING] = warning_out;
		src[`OTFS_C_READY]  = ready_flag;
		src[`OTFS_C_MOVE]   = moving_flag;
		src[`OTFS_C_END]    = position_end_flag;
		src[`OTFS_C_HOMEP]  = home_position_flag;
		src[`OTFS_C_TORQUE] = torque_exceeded_flag;
		// Pulse width is whatever the motion core gives
		src[`OTFS_C_SHAFT]  = shaft_step_pulse;
		for (int k = 0; k < `OTFS_NUM_ZONE; k++) begin
			src[`OTFS_C_ZONE1 + k] = zone_flag[k];
		end
		src[`OTFS_C_BUSY]   = internal_processing_flag;
		src[`OTFS_C_POWER]  = main_power_state;
	end

	assign idx      = otfs_reg_idx(paddr);
	assign setup_rd = psel && !penable && !pwrite;
	assign wr_acc   = psel && penable && pwrite && pstrb[0];
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && (idx == ($clog2(NREG+1))'(NREG));

	always_comb begin
		st_d = st_q;
		for (int t = 0; t < `OTFS_NUM_TERM; t++) begin
			st_d.term[t] = otfs_pick(st_q.sel[t], src);
			if (wr_acc && idx == ($clog2(NREG+1))'(t))
				st_d.sel[t] = pwdata[`OTFS_CODE_W-1:0];
		end
		// Read data captured in setup so prdata comes from a flop
		if (setup_rd) begin
			st_d.rdata = '0;
			if (idx < ($clog2(NREG+1))'(`OTFS_NUM_TERM))
				st_d.rdata[`OTFS_CODE_W-1:0] = st_q.sel[idx[2:0]];
			else if (idx == ($clog2(NREG+1))'(`OTFS_NUM_TERM))
				st_d.rdata[`OTFS_NUM_TERM-1:0] = st_q.term;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q.sel   <= `OTFS_SEL_RST;
			st_q.term  <= '0;
			st_q.rdata <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata            = st_q.rdata;
	assign output_terminal_0 = st_q.term[0];
	assign output_terminal_1 = st_q.term[1];
	assign output_terminal_2 = st_q.term[2];
	assign output_terminal_3 = st_q.term[3];
	assign output_terminal_4 = st_q.term[4];
	assign output_terminal_5 = st_q.term[5];

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sel_hold_a: assert property (!wr_acc |=> $stable(st_q.sel))
		else $error("select code changed without a write");
	sel_write_a: assert property (
		wr_acc && idx == '0 |=> st_q.sel[0] == $past(pwdata[`OTFS_CODE_W-1:0]))
		else $error("terminal 0 code not written");
	reset_code_a: assert property ($rose(presetn) |-> st_q.sel == `OTFS_SEL_RST)
		else $error("select codes wrong after reset");
	// Echo checks sit on terminal 0, except alarm on terminal 5 and ready on terminal 3
	unused_off_a: assert property (
		st_q.sel[0] == `OTFS_C_UNUSED |=> !output_terminal_0)
		else $error("unused terminal active");
	fwd_echo_a: assert property (
		st_q.sel[0] == `OTFS_C_FORWARD |=> output_terminal_0 == $past(forward_run))
		else $error("forward echo wrong");
	stop_echo_a: assert property (
		st_q.sel[0] == `OTFS_C_STOP |=> output_terminal_0 == $past(stop_cmd))
		else $error("stop echo wrong");
	ms_echo_a: assert property (
		st_q.sel[0] == `OTFS_C_DIRECT0 + 5
		|=> output_terminal_0 == $past(direct_position_sel[5]))
		else $error("direct start echo wrong");
	gen_bit_a: assert property (
		st_q.sel[0] == `OTFS_C_GEN0 + 15 |=> output_terminal_0 == $past(general_bit[15]))
		else $error("general bit wrong");
	data_num_a: assert property (
		st_q.sel[0] == `OTFS_C_DN0 + 5 |=> output_terminal_0 == $past(data_number_bit[5]))
		else $error("data number echo wrong");
	slot_echo_a: assert property (
		st_q.sel[0] == `OTFS_C_SLOT |=> output_terminal_0 == $past(slot_sensor))
		else $error("slot sensor echo wrong");
	alarm_nc_a: assert property (
		st_q.sel[5] == `OTFS_C_ALARM |=> output_terminal_5 != $past(alarm_out))
		else $error("alarm not normally closed");
	warn_out_a: assert property (
		st_q.sel[0] == `OTFS_C_WARNING |=> output_terminal_0 == $past(warning_out))
		else $error("warning output wrong");
	ready_out_a: assert property (
		st_q.sel[3] == `OTFS_C_READY ##1 st_q.sel[3] == `OTFS_C_READY && $fell(ready_flag)
		|=> !output_terminal_3)
		else $error("ready output late");
	move_out_a: assert property (
		st_q.sel[0] == `OTFS_C_MOVE |=> output_terminal_0 == $past(moving_flag))
		else $error("moving output wrong");
	end_out_a: assert property (
		st_q.sel[0] == `OTFS_C_END |=> output_terminal_0 == $past(position_end_flag))
		else $error("positioning end output wrong");
	home_pos_a: assert property (
		st_q.sel[0] == `OTFS_C_HOMEP |=> output_terminal_0 == $past(home_position_flag))
		else $error("home position output wrong");
	torque_out_a: assert property (
		st_q.sel[0] == `OTFS_C_TORQUE |=> output_terminal_0 == $past(torque_exceeded_flag))
		else $error("torque output wrong");
	shaft_pulse_a: assert property (
		st_q.sel[0] == `OTFS_C_SHAFT |=> output_terminal_0 == $past(shaft_step_pulse))
		else $error("shaft pulse output wrong");
	zone_three_a: assert property (
		st_q.sel[0] == `OTFS_C_ZONE1 + 2 |=> output_terminal_0 == $past(zone_flag[2]))
		else $error("zone three output wrong");
	busy_out_a: assert property (
		st_q.sel[0] == `OTFS_C_BUSY
		|=> output_terminal_0 == $past(internal_processing_flag))
		else $error("busy output wrong");
	power_out_a: assert property (
		st_q.sel[0] == `OTFS_C_POWER |=> output_terminal_0 == $past(main_power_state))
		else $error("main power output wrong");
	// Code right after the direct starts, and codes past the source vector
	undef_off_a: assert property (
		st_q.sel[0] == `OTFS_C_DIRECT0 + `OTFS_NUM_MS || st_q.sel[0] >= `OTFS_SRC_W
		|=> !output_terminal_0)
		else $error("undefined code drove terminal");

	pulse_seen_c: cover property (st_q.sel[0] == `OTFS_C_SHAFT ##1 output_terminal_0);
	code_write_c: cover property (wr_acc ##1 psel && !penable && !pwrite);
	alarm_trip_c: cover property (st_q.sel[5] == `OTFS_C_ALARM ##1 $fell(output_terminal_5));
	bad_addr_c:   cover property (pslverr);

endmodule

// [dv/otfs_host_model.sv]
// Purpose: Host side that sets general bits and reads the terminals
// Assumes: Network link updates general bits on rising edges only
// Notes:   Link is one register stage; terminals seen one clock late
`timescale 1ns/1ps

module otfs_host_model (
	input  wire logic        pclk,
	input  wire logic [15:0] gen_set,
	input  wire logic [5:0]  term,
	output logic      [15:0] general_bit,
	output logic      [5:0]  seen
);
	always @(posedge pclk) begin
		general_bit <= gen_set;
		seen        <= term;
	end
endmodule

// [dv/output_terminal_function_selector_test.sv]
// Purpose: Self-checking bench for the terminal function selector
// Assumes: APB slave answers by pready; terminals lag sources
// Notes:   One source vector indexed by assignment code
`timescale 1ns/1ps

module output_terminal_function_selector_test;
	import otfs_pkg::*;
	logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	otfs_addr_t   paddr = '0;
	logic [31:0]  pwdata = '0, prdata, rd;
	logic [3:0]   pstrb = 4'hf;
	logic         pready, pslverr, err;
	logic [127:0] src = '0;
	logic [15:0]  gen;
	wire  [5:0]   term, seen;
	int           fails = 0, tests_run = 0;
	int           rst_code[6] = '{70, 69, 73, 67, 66, 65};

	always #12.5 pclk = ~pclk;

	otfs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .forward_run(src[1]), .reverse_run(src[2]),
		.home_cmd(src[3]), .start_cmd(src[4]), .sequential_begin(src[5]), .jog_plus(src[6]),
		.jog_minus(src[7]), .direct_position_sel(src[13:8]), .free_cmd(src[16]),
		.excite_on(src[17]), .stop_cmd(src[18]), .general_bit(gen),
		.data_number_bit(src[53:48]), .plus_limit_sensor(src[60]),
		.minus_limit_sensor(src[61]), .origin_sensor(src[62]), .slot_sensor(src[63]),
		.alarm_out(src[65]), .warning_out(src[66]), .ready_flag(src[67]),
		.moving_flag(src[68]), .position_end_flag(src[69]), .home_position_flag(src[70]),
		.torque_exceeded_flag(src[71]), .shaft_step_pulse(src[72]), .zone_flag(src[75:73]),
		.internal_processing_flag(src[80]), .main_power_state(src[82]),
		.output_terminal_0(term[0]), .output_terminal_1(term[1]), .output_terminal_2(term[2]),
		.output_terminal_3(term[3]), .output_terminal_4(term[4]), .output_terminal_5(term[5]));

	otfs_host_model host (.pclk(pclk), .gen_set(src[47:32]), .term(term), .general_bit(gen),
		.seen(seen));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input otfs_addr_t a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Expected level of a terminal fed by code c
	function automatic logic expt(input int c);
		logic d;
		d = (c >= 1 && c <= 13) || (c >= 16 && c <= 18) || (c >= 32 && c <= 53) ||
			(c >= 60 && c <= 63) || (c >= 65 && c <= 75) || c == 80 || c == 82;
		return !d ? 1'b0 : (c == 65) ? !src[65] : src[c];
	endfunction

	// Five edges cover the link stage, the terminal register and the host sample
	task automatic drive(input int c, input logic [127:0] s);
		src <= s;
		repeat (5) @(posedge pclk);
		chk({31'h0, seen[0]}, {31'h0, expt(c)}, "terminal 0");
	endtask

	task automatic results;
		$display("Counts: %0d compared, %0d failed", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		chk({26'h0, seen}, 32'h20, "reset terminals");
		foreach (rst_code[i]) begin
			apb(1'b0, otfs_addr_t'(4 * i), 32'h0);
			chk(rd, 32'(rst_code[i]), "reset code");
		end
		$display("test reset done");
		// One-hot then all-but-one catches a neighbour picked by mistake
		for (int c = 0; c < 256; c++) begin
			apb(1'b1, 8'h00, 32'(c));
			drive(c, 128'h1 << c);
			drive(c, ~(128'h1 << c));
		end
		$display("test code sweep done");
		src <= 128'h54;
		for (int i = 0; i < 6; i++) apb(1'b1, otfs_addr_t'(4 * i), 32'(i + 1));
		pstrb <= 4'h0;
		apb(1'b1, 8'h00, 32'h12);
		pstrb <= 4'hf;
		apb(1'b1, 8'h18, 32'h0);
		repeat (3) @(posedge pclk);
		apb(1'b0, 8'h18, 32'h0);
		chk(rd, 32'h2a, "status");
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, otfs_addr_t'(4 * i), 32'h0);
			chk(rd, 32'(i + 1), "code readback");
		end
		apb(1'b1, 8'h1c, 32'h5);
		chk({31'h0, err}, 32'h1, "unmapped write error");
		apb(1'b0, 8'h40, 32'h0);
		chk({30'h0, err, |rd}, 32'h2, "unmapped read");
		$display("test terminals and registers done");
		results();
	end

	// About six times the expected run length
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		results();
	end
endmodule
